// ---- inc/bec_pkg.sv ----
// block error checker: shared constants, register map and state encodings
// assumes a 50 MHz system clock and an AXI4-Lite master with 32-bit data
package bec_pkg;
    // clock and timing
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int SYS_PERIOD_NS = 20;
    localparam int CLK_TO_NS = 1600;
    localparam int CLK_TO_CYC_I = (CLK_TO_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [7:0] CLK_TO_CYC = CLK_TO_CYC_I[7:0];
    localparam int TMO_MS = 100;
    localparam logic [6:0] DATA_TO_BITS = 7'h40;
    localparam logic [2:0] SYNC_LOSS_BLKS = 3'h4;

    // register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_MAXBLK = 6'h04;
    localparam logic [5:0] OFS_MAXERR = 6'h08;
    localparam logic [5:0] OFS_TMO = 6'h0C;
    localparam logic [5:0] OFS_GDIV = 6'h10;
    localparam logic [5:0] OFS_GDEN = 6'h14;
    localparam logic [5:0] OFS_GRDLY = 6'h18;
    localparam logic [5:0] OFS_GERR = 6'h1C;
    localparam logic [5:0] OFS_STAT = 6'h20;
    localparam logic [5:0] OFS_BLKCNT = 6'h24;
    localparam logic [5:0] OFS_ERRCNT = 6'h28;

    // control bits
    localparam int CB_RUN = 0;
    localparam int CB_ST = 1;
    localparam int CB_INV = 2;
    localparam int CB_DENLO = 3;
    localparam int CB_MSB = 4;
    localparam int CB_RST = 5;
    localparam int CB_PRBS = 6;
    localparam logic [1:0] PRBS_9 = 2'h0;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] MAXBLK_RST = 32'h0001_86A0;
    localparam logic [31:0] MAXERR_RST = 32'h0000_0064;
    localparam logic [31:0] GDIV_RST = 32'h0000_0003;
    localparam logic [31:0] GDEN_RST = 32'h03E8_03E8;
    localparam logic [31:0] GRDLY_RST = 32'h0000_03E8;
    localparam logic [31:0] GERR_RST = 32'h0000_0000;

    // termination cause bits
    localparam int TC_BLK = 0;
    localparam int TC_ERR = 1;
    localparam int TC_TMO = 2;

    // checksum
    localparam int CRC_W = 16;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [4:0] CRC_LAST = 5'h0F;

    // sequence taps
    localparam int P9_A = 8;
    localparam int P9_B = 4;
    localparam int P15_A = 14;
    localparam int P15_B = 13;
    localparam int P23_A = 22;
    localparam int P23_B = 17;
    localparam logic [22:0] PRBS_SEED = 23'h7F_FFFF;
    localparam logic [15:0] RND_SEED = 16'hACE1;

    // pin indexes
    localparam int PIN_CLK = 0;
    localparam int PIN_DAT = 1;
    localparam int PIN_DEN = 2;
    localparam int PIN_RST = 3;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {CHK_DATA = 3'h1, CHK_CRC = 3'h2, CHK_SKIP = 3'h4} bec_chk_e;
    typedef enum logic [2:0] {GEN_WAIT = 3'h1, GEN_ON = 3'h2, GEN_OFF = 3'h4} bec_gen_e;
endpackage

// ---- hdl/bec_crc16.sv ----
// bitwise 16-bit checksum register, msb-first shift
// assumes clr and en come from logic on sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module bec_crc16 (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // control
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic bit_i,
    // result
    output logic [15:0] crc_o
);
    import bec_pkg::*;

    typedef struct packed {
        logic [15:0] crc;
    } bec_crc_s;

    bec_crc_s q;
    bec_crc_s d;

    // clear wins; otherwise fold one bit in
    always_comb begin
        d = q;
        if (clr_i) begin
            d.crc = CRC_INIT;
        end else if (en_i) begin
            d.crc = {q.crc[14:0], 1'b0} ^ ((bit_i ^ q.crc[15]) ? CRC_POLY : 16'h0000);
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q.crc <= CRC_INIT;
        end else begin
            q <= d;
        end
    end

    assign crc_o = q.crc;
endmodule
`default_nettype wire

// ---- hdl/bec_top.sv ----
// block error checker with self-test generator and AXI4-Lite registers
// assumes link pins are asynchronous and sampled by sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module bec_top #(
    parameter int TMO_CYC = bec_pkg::TMO_MS * (bec_pkg::SYS_CLK_HZ / 1000)
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // axi4-lite write
    input wire logic [5:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [5:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // link inputs
    input wire logic link_clk_i,
    input wire logic link_data_i,
    input wire logic link_den_i,
    input wire logic link_restart_i,
    // self-test outputs
    output logic st_clk_o,
    output logic st_data_o,
    output logic st_den_o
);
    import bec_pkg::*;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic clk_d;
        logic rst_d;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [5:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [31:0] maxblk;
        logic [31:0] maxerr;
        logic [31:0] tmo;
        logic [31:0] gdiv;
        logic [31:0] gden_t;
        logic [31:0] grdly;
        logic [31:0] gerr;
        bec_chk_e cst;
        logic [4:0] ccnt;
        logic [15:0] rx;
        logic [31:0] blkcnt;
        logic [31:0] errcnt;
        logic [31:0] tcnt;
        logic [7:0] clk_idle;
        logic [6:0] dat_idle;
        logic last_bit;
        logic [2:0] badrun;
        logic sync;
        logic running;
        logic [2:0] term;
        bec_gen_e gst;
        logic [7:0] gdivc;
        logic gclk;
        logic gdat;
        logic gden;
        logic [15:0] gcnt;
        logic [22:0] prbs;
        logic [15:0] rnd;
        logic [15:0] gsh;
        logic gload;
        logic rst_pend;
    } bec_st_s;

    bec_st_s q;
    bec_st_s d;

    logic inv_eff, link_edge, rx_bit, user_bit, blk_done, blk_bad, gtick, rst_edge;
    logic prbs_fb, err_inj, crc_clr, crc_en, gcrc_clr, gcrc_en;
    logic [15:0] crc_q, gcrc_q, rx_word;
    logic [31:0] stat_w;

    // byte order of the checksum field
    function automatic logic [15:0] bec_ord(input logic msb, input logic [15:0] w);
        bec_ord = msb ? w : {w[7:0], w[15:8]};
    endfunction

    // byte-lane merge for writes
    function automatic logic [31:0] bec_wr(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        bec_wr = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // derived terms
    assign inv_eff = q.ctrl[CB_INV] ^ (q.ctrl[CB_PRBS +: 2] != PRBS_9);
    assign link_edge = q.s2[PIN_CLK] & ~q.clk_d;
    assign rx_bit = q.s2[PIN_DAT] ^ inv_eff;
    assign user_bit = q.s2[PIN_DEN] ^ q.ctrl[CB_DENLO];
    assign rx_word = {q.rx[14:0], rx_bit};
    assign blk_done = link_edge && (q.cst == CHK_CRC) && (q.ccnt == CRC_LAST);
    assign blk_bad = bec_ord(q.ctrl[CB_MSB], rx_word) != crc_q;
    assign gtick = q.ctrl[CB_ST] && (q.gdivc == 8'h00) && q.gclk;
    assign rst_edge = q.s2[PIN_RST] & ~q.rst_d;
    assign err_inj = q.rnd < q.gerr[15:0];
    assign stat_w = {25'h0, q.term, q.running, q.sync, (q.dat_idle < DATA_TO_BITS), (q.clk_idle < CLK_TO_CYC)};

    // sequence feedback for the selected length
    always_comb begin
        unique case (q.ctrl[CB_PRBS +: 2])
            2'h1: prbs_fb = q.prbs[P15_A] ^ q.prbs[P15_B];
            2'h2: prbs_fb = q.prbs[P23_A] ^ q.prbs[P23_B];
            default: prbs_fb = q.prbs[P9_A] ^ q.prbs[P9_B];
        endcase
    end

    // checksum registers for receive and generate paths
    bec_crc16 u_crc_rx (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .clr_i(crc_clr),
        .en_i(crc_en),
        .bit_i(rx_bit),
        .crc_o(crc_q)
    );

    bec_crc16 u_crc_gen (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .clr_i(gcrc_clr),
        .en_i(gcrc_en),
        .bit_i(prbs_fb),
        .crc_o(gcrc_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        d = q;
        crc_clr = 1'b0;
        crc_en = 1'b0;
        gcrc_clr = 1'b0;
        gcrc_en = 1'b0;
        // two-stage pin synchronisers
        d.s1 = {link_restart_i, link_den_i, link_data_i, link_clk_i};
        d.s2 = q.s1;
        d.clk_d = q.s2[PIN_CLK];
        d.rst_d = q.s2[PIN_RST];

        // receive path, one step per link clock rising edge
        if (link_edge) begin
            d.clk_idle = 8'h00;
            d.last_bit = rx_bit;
            if (rx_bit != q.last_bit) begin
                d.dat_idle = 7'h00;
            end else if (q.dat_idle != DATA_TO_BITS) begin
                d.dat_idle = q.dat_idle + 7'h01;
            end
            unique case (q.cst)
                CHK_DATA: begin
                    if (user_bit) begin
                        crc_en = 1'b1;
                    end else begin
                        d.rx = rx_word;
                        d.ccnt = 5'h01;
                        d.cst = CHK_CRC;
                    end
                end
                CHK_CRC: begin
                    d.rx = rx_word;
                    d.ccnt = q.ccnt + 5'h01;
                    if (q.ccnt == CRC_LAST) begin
                        d.cst = CHK_SKIP;
                        crc_clr = 1'b1;
                    end
                end
                CHK_SKIP: begin
                    if (user_bit) begin
                        crc_en = 1'b1;
                        d.cst = CHK_DATA;
                    end
                end
            endcase
        end else if (q.clk_idle != CLK_TO_CYC) begin
            d.clk_idle = q.clk_idle + 8'h01;
        end
        if (q.clk_idle == CLK_TO_CYC) begin
            d.dat_idle = DATA_TO_BITS; // no clock means no data seen
        end

        // block verdict, sync tracking and counters
        if (blk_done) begin
            if (!blk_bad) begin
                d.sync = 1'b1;
                d.badrun = 3'h0;
            end else if (q.badrun == SYNC_LOSS_BLKS - 3'h1) begin
                d.sync = 1'b0;
            end else begin
                d.badrun = q.badrun + 3'h1;
            end
            if (q.running) begin
                d.blkcnt = q.blkcnt + 32'h1;
                if (blk_bad) begin
                    d.errcnt = q.errcnt + 32'h1;
                end
            end
        end

        // termination checks
        if (q.running) begin
            d.tcnt = q.tcnt + 32'h1;
            if (d.tcnt >= q.tmo) begin
                d.term[TC_TMO] = 1'b1;
            end
            if (blk_done && d.blkcnt >= q.maxblk) begin
                d.term[TC_BLK] = 1'b1;
            end
            if (blk_done && d.errcnt >= q.maxerr) begin
                d.term[TC_ERR] = 1'b1;
            end
            if (d.term != 3'h0) begin
                d.running = 1'b0;
            end
        end

        // self-test clock divider
        if (!q.ctrl[CB_ST]) begin
            d.gclk = 1'b0;
            d.gdivc = q.gdiv[7:0];
            d.gst = GEN_ON;
            d.gcnt = 16'h0000;
            d.gden = q.ctrl[CB_DENLO];
            d.gdat = 1'b0;
            gcrc_clr = 1'b1;
        end else if (q.gdivc == 8'h00) begin
            d.gdivc = q.gdiv[7:0];
            d.gclk = ~q.gclk;
        end else begin
            d.gdivc = q.gdivc - 8'h01;
        end
        d.rst_pend = (q.rst_pend & ~gtick) | (rst_edge & q.ctrl[CB_RST]);
        if (q.gload) begin
            d.gsh = bec_ord(q.ctrl[CB_MSB], gcrc_q);
            d.gload = 1'b0;
        end

        // self-test generator, one bit per falling edge of its clock
        if (gtick) begin
            d.prbs = {q.prbs[21:0], prbs_fb};
            d.rnd = {q.rnd[14:0], q.rnd[15] ^ q.rnd[13] ^ q.rnd[12] ^ q.rnd[10]};
            d.gdat = prbs_fb ^ inv_eff;
            d.gden = q.ctrl[CB_DENLO];
            d.gcnt = q.gcnt + 16'h0001;
            if (q.rst_pend) begin
                d.gst = GEN_WAIT;
                d.gcnt = 16'h0000;
            end else begin
                unique case (q.gst)
                    GEN_WAIT: begin
                        if (d.gcnt >= q.grdly[15:0]) begin
                            d.gst = GEN_ON;
                            d.gcnt = 16'h0000;
                            gcrc_clr = 1'b1;
                        end
                    end
                    GEN_ON: begin
                        d.gden = ~q.ctrl[CB_DENLO];
                        d.gdat = prbs_fb ^ inv_eff ^ err_inj;
                        gcrc_en = 1'b1;
                        if (d.gcnt >= q.gden_t[15:0]) begin
                            d.gst = GEN_OFF;
                            d.gcnt = 16'h0000;
                            d.gload = 1'b1;
                        end
                    end
                    GEN_OFF: begin
                        if (q.gcnt < CRC_W) begin
                            d.gdat = q.gsh[15] ^ inv_eff;
                            d.gsh = {q.gsh[14:0], 1'b0};
                        end
                        if (d.gcnt >= q.gden_t[31:16]) begin
                            d.gst = GEN_ON;
                            d.gcnt = 16'h0000;
                            gcrc_clr = 1'b1;
                        end
                    end
                endcase
            end
        end

        // axi write channel, address and data in either order
        if (s_axi_awvalid_i && q.awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && q.wready) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata_i;
            d.wstrb = s_axi_wstrb_i;
        end
        if (q.bvalid && s_axi_bready_i) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            unique case (q.awaddr)
                OFS_CTRL: begin
                    d.ctrl = bec_wr(q.ctrl, q.wdata, q.wstrb);
                    if (d.ctrl[CB_RUN] && !q.running) begin
                        d.running = 1'b1; // restart clears the results
                        d.term = 3'h0;
                        d.tcnt = 32'h0;
                        d.blkcnt = 32'h0;
                        d.errcnt = 32'h0;
                    end else if (!d.ctrl[CB_RUN]) begin
                        d.running = 1'b0;
                    end
                end
                OFS_MAXBLK: d.maxblk = bec_wr(q.maxblk, q.wdata, q.wstrb);
                OFS_MAXERR: d.maxerr = bec_wr(q.maxerr, q.wdata, q.wstrb);
                OFS_TMO: d.tmo = bec_wr(q.tmo, q.wdata, q.wstrb);
                OFS_GDIV: d.gdiv = bec_wr(q.gdiv, q.wdata, q.wstrb);
                OFS_GDEN: d.gden_t = bec_wr(q.gden_t, q.wdata, q.wstrb);
                OFS_GRDLY: d.grdly = bec_wr(q.grdly, q.wdata, q.wstrb);
                OFS_GERR: d.gerr = bec_wr(q.gerr, q.wdata, q.wstrb);
                default: d.bresp = RESP_SLVERR;
            endcase
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;

        // axi read channel
        if (q.rvalid && s_axi_rready_i) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            unique case (s_axi_araddr_i)
                OFS_CTRL: d.rdata = q.ctrl;
                OFS_MAXBLK: d.rdata = q.maxblk;
                OFS_MAXERR: d.rdata = q.maxerr;
                OFS_TMO: d.rdata = q.tmo;
                OFS_GDIV: d.rdata = q.gdiv;
                OFS_GDEN: d.rdata = q.gden_t;
                OFS_GRDLY: d.rdata = q.grdly;
                OFS_GERR: d.rdata = q.gerr;
                OFS_STAT: d.rdata = stat_w;
                OFS_BLKCNT: d.rdata = q.blkcnt;
                OFS_ERRCNT: d.rdata = q.errcnt;
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
        d.arready = !d.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            q.cst <= CHK_DATA;
            q.gst <= GEN_ON;
            q.ctrl <= CTRL_RST;
            q.maxblk <= MAXBLK_RST;
            q.maxerr <= MAXERR_RST;
            q.tmo <= 32'(TMO_CYC);
            q.gdiv <= GDIV_RST;
            q.gden_t <= GDEN_RST;
            q.grdly <= GRDLY_RST;
            q.gerr <= GERR_RST;
            q.prbs <= PRBS_SEED;
            q.rnd <= RND_SEED;
            q.clk_idle <= CLK_TO_CYC;
            q.dat_idle <= DATA_TO_BITS;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready_o = q.awready;
    assign s_axi_wready_o = q.wready;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = q.arready;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rresp_o = q.rresp;
    assign s_axi_rdata_o = q.rdata;
    assign st_clk_o = q.gclk;
    assign st_data_o = q.gdat;
    assign st_den_o = q.gden;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking bec_cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_blk_seen;
        blk_done && q.running;
    endsequence

    a_crc_error: assert property (s_blk_seen ##0 blk_bad |=> q.errcnt == $past(q.errcnt) + 32'h1 || !q.running)
        else $error("bad block not counted");
    a_blk_count: assert property (s_blk_seen |=> q.blkcnt == $past(q.blkcnt) + 32'h1 || !q.running)
        else $error("block not counted");
    a_gate_user: assert property (link_edge && q.cst == CHK_DATA && (q.s2[PIN_DEN] != q.ctrl[CB_DENLO]) |-> crc_en)
        else $error("user bit not folded into checksum");
    a_gate_crc: assert property (link_edge && q.cst == CHK_DATA && (q.s2[PIN_DEN] == q.ctrl[CB_DENLO]) |=> q.cst == CHK_CRC)
        else $error("checksum bit not taken");
    a_clk_lost: assert property (!link_edge [*8] ##1 (q.clk_idle == CLK_TO_CYC && !link_edge) |=> !stat_w[0])
        else $error("clock missing not shown");
    a_term_blk: assert property (s_blk_seen ##0 (q.blkcnt + 32'h1 >= q.maxblk) |=> !q.running && q.term[TC_BLK])
        else $error("block limit ignored");
    a_term_err: assert property (s_blk_seen ##0 blk_bad ##0 (q.errcnt + 32'h1 >= q.maxerr) |=> q.term[TC_ERR])
        else $error("error limit ignored");
    a_timeout: assert property (q.running && (q.tcnt + 32'h1 >= q.tmo) |=> !q.running && q.term[TC_TMO])
        else $error("timeout ignored");
    a_sync_drop: assert property (blk_done && blk_bad && q.badrun == SYNC_LOSS_BLKS - 3'h1 |=> !q.sync)
        else $error("sync not dropped");
    a_gen_gate: assert property (gtick && !q.rst_pend && q.gst == GEN_ON |=> st_den_o != q.ctrl[CB_DENLO])
        else $error("generator gate not active in on time");
endmodule
`default_nettype wire

// ---- dv/bec_dut_model.sv ----
// link source model; the clock rests low between frames
`timescale 1ns/1ps
`default_nettype none
module bec_dut_model (
    // link pins
    output logic clk_o,
    output logic dat_o,
    output logic den_o
);
    initial {clk_o, dat_o, den_o} = 3'h0;
    // one frame: 16 user bits, then their checksum
    task automatic send(input logic [15:0] d, input logic inv, lo, msb, bad);
        logic [15:0] c = 16'hFFFF;
        for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
        c[0] ^= bad;
        if (!msb) c = {c[7:0], c[15:8]};
        for (int i = 0; i < 32; i++) begin
            dat_o <= (i < 16 ? d[15 - i] : c[31 - i]) ^ inv;
            den_o <= lo ^ (i < 16);
            #80 clk_o <= 1'b1;
            #80 clk_o <= 1'b0;
        end
        dat_o <= ~dat_o; // released line shows the inverse
    endtask
endmodule
`default_nettype wire

// ---- dv/bec_top_tb.sv ----
// checker bench; the link model drives clock, data and gate pins unless loopback is on; the bench drives restart
`timescale 1ns/1ps
`default_nettype none
module bec_top_tb;
    import bec_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; $display("ERROR %0t %h %h", $time, a, e); end end
    logic clk = 0, nrst = 0, awv = 0, wv = 0, arv = 0, lb = 0, rs = 0, awr, wrr, bv, arr, rv, mc, md, me, sc, sd, se;
    logic [5:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, rdd;
    logic [1:0] br, rr, rsp;
    logic [8:0] rows [7] = '{9'h000, 9'h104, 9'h008, 9'h110, 9'h01C, 9'h040, 9'h180};
    int err_count = 0, n_checks = 0;
    // clock and hang guard
    always #10 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end
    // design and link source
    bec_top #(.TMO_CYC(2000)) bec_top_i (.sys_clk_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
        .link_clk_i(lb ? sc : mc), .link_data_i(lb ? sd : md), .link_den_i(lb ? se : me), .link_restart_i(rs),
        .st_clk_o(sc), .st_data_o(sd), .st_den_o(se));
    bec_dut_model bec_dut_model_i (.clk_o(mc), .dat_o(md), .den_o(me));
    // bus tasks and verdict
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ad = 1'b0, dd = 1'b0;
        {awa, wd, awv, wv} <= {a, d, 2'h3};
        // address and data are each released at the edge that takes them
        while (!(ad && dd)) begin
            @(posedge clk);
            if (!ad && awr) begin
                ad = 1'b1;
                awv <= 1'b0;
            end
            if (!dd && wrr) begin
                dd = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (!bv);
        `CHK(br, e)
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] m, e);
        {ara, arv} <= {a, 1'b1};
        do @(posedge clk); while (!arr);
        arv <= 0;
        do @(posedge clk); while (!rv);
        {rdd, rsp} = {rdat, rr};
        `CHK(rdd & m, e)
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one block with settle time; restart of a measurement
    task automatic blk(input logic [15:0] d, input logic [8:0] c);
        bec_dut_model_i.send(d, c[2] ^ (c[7:6] != 2'h0), c[3], c[4], c[8]);
        repeat (8) @(posedge clk);
    endtask
    task automatic go(input logic [31:0] c);
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        wr(OFS_CTRL, c, RESP_OKAY);
    endtask
    // reset, table of blocks, terminations, loopback
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        rd(6'h3C, '1, 32'h0);
        `CHK(rsp, RESP_SLVERR)
        wr(OFS_STAT, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 7; i++) begin
            go({24'h0, rows[i][7:0]} | 32'h1);
            blk(16'hB38E ^ 16'(i), rows[i]);
            rd(OFS_BLKCNT, '1, 32'h1);
            rd(OFS_ERRCNT, '1, {31'h0, rows[i][8]});
        end
        wr(OFS_MAXBLK, 32'h2, RESP_OKAY);
        go(32'h1);
        repeat (3) blk(16'h1234, 9'h0);
        rd(OFS_BLKCNT, '1, 32'h2);
        rd(OFS_STAT, 32'h79, 32'h11);
        repeat (100) @(posedge clk);
        rd(OFS_STAT, 32'h3, 32'h0);
        wr(OFS_MAXERR, 32'h1, RESP_OKAY);
        go(32'h1);
        repeat (2100) @(posedge clk);
        rd(OFS_STAT, 32'h70, 32'h40);
        wr(OFS_GDEN, 32'h0010_0020, RESP_OKAY);
        lb <= 1;
        go(32'h3);
        repeat (1000) @(posedge clk);
        rd(OFS_STAT, 32'h74, 32'h14);
        wr(OFS_GERR, 32'h8000, RESP_OKAY);
        go(32'h3);
        repeat (2500) @(posedge clk);
        rd(OFS_STAT, 32'h34, 32'h20);
        // external restart holds the generator gate off for the delay
        wr(OFS_GRDLY, 32'h40, RESP_OKAY);
        go(32'h23);
        repeat (20) @(posedge clk);
        rs <= 1;
        repeat (400) @(posedge clk);
        `CHK(se, 1'b0)
        repeat (200) @(posedge clk);
        `CHK(se, 1'b1)
        // reset in mid-run returns status and the block limit to their reset values
        {nrst, rs} <= 2'h0;
        repeat (3) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        rd(OFS_STAT, 32'h7F, 32'h0);
        rd(OFS_MAXBLK, '1, MAXBLK_RST);
        end_sim();
    end
endmodule
`default_nettype wire
